// ===== design/ext_data_mem_stretch.sv
`timescale 1ns/10ps
`include "ext_data_mem_stretch_params.svh"
module ext_data_mem_stretch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_ptr8,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] port2_value,
  output logic done,
  output logic [7:0] rdata,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] addr_hi,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe
);
  localparam logic [11:0] CtrlAddr = 12'(`EDMS_CTRL_IDX * 4);
  // ----------------------------------------
  // decode and timing functions
  // ----------------------------------------
  function automatic ext_data_mem_stretch_pkg::reg_sel_t decode(input logic [11:0] a);
    if (a == CtrlAddr) begin
      return ext_data_mem_stretch_pkg::REG_CTRL;
    end else if (a == `EDMS_PAGE_ADDR) begin
      return ext_data_mem_stretch_pkg::REG_PAGE;
    end else if (a == `EDMS_STAT_ADDR) begin
      return ext_data_mem_stretch_pkg::REG_STAT;
    end
    return ext_data_mem_stretch_pkg::REG_NONE;
  endfunction

  // stretch machine cycles per code
  function automatic logic [3:0] stretch_cycles(input logic [2:0] c);
    return c[2] ? {2'h0, c[1:0]} + 4'h7 : {1'b0, c};
  endfunction
  // phase lengths count system clocks, so every width follows the system clock rate
  function automatic logic [4:0] ale_len(input logic [2:0] c);
    return c[2] ? `EDMS_ALE_SLOW : `EDMS_ALE_BASE;
  endfunction
  function automatic logic [4:0] setup_len(input logic [2:0] c);
    return (c == 3'h0) ? `EDMS_PHASE_BASE :
           (c[2] ? `EDMS_PHASE_SLOW : `EDMS_PHASE_MID);
  endfunction
  // strobe: 2 clocks at code 0, else four per code step
  function automatic logic [4:0] strobe_len(input logic [2:0] c, input logic short1);
    logic [4:0] n;
    n = (c == 3'h0) ? `EDMS_PHASE_BASE : {c, 2'b00};
    return short1 ? n - 5'h01 : n;
  endfunction
  function automatic logic [4:0] hold_len(input logic [2:0] c, input logic short1);
    return setup_len(c) + {4'h0, short1};
  endfunction
  // ----------------------------------------
  // state
  // ----------------------------------------
  ext_data_mem_stretch_pkg::phase_t state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [7:0] ad_o_q, ad_o_d, ad_s1_q, ad_s2_q;
  logic [2:0] page_q, page_d, code_q, code_d;
  logic [4:0] cnt_q, cnt_d;
  logic short_q, short_d, wr_q, wr_d, done_q, done_d;
  logic [15:0] addr_q, addr_d;
  logic ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, ad_oe_q, ad_oe_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] axi_rdata_q, axi_rdata_d;
  logic wr_fire, rd_fire, start;
  ext_data_mem_stretch_pkg::reg_sel_t wsel, rsel;
  // register bus handshakes and core request acceptance
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign wsel = decode(s_axi_awaddr);
  assign rsel = decode(s_axi_araddr);
  assign req_ready = (state_q == ext_data_mem_stretch_pkg::S_IDLE);
  assign start = req_valid && req_ready;

  // register bus: writes, reads and responses
  always_comb begin
    ctrl_d = ctrl_q;
    page_d = page_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    axi_rdata_d = axi_rdata_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = (wsel == ext_data_mem_stretch_pkg::REG_NONE) ? 2'h2 : 2'h0;
      if (wsel == ext_data_mem_stretch_pkg::REG_CTRL && s_axi_wstrb[0]) begin
        ctrl_d = s_axi_wdata[7:0];
      end
      if (wsel == ext_data_mem_stretch_pkg::REG_PAGE && s_axi_wstrb[0]) begin
        page_d = s_axi_wdata[2:0];
      end
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = 2'h0;
      case (rsel)
        ext_data_mem_stretch_pkg::REG_CTRL: axi_rdata_d = {24'h0, ctrl_q};
        ext_data_mem_stretch_pkg::REG_PAGE: axi_rdata_d = {29'h0, page_q};
        ext_data_mem_stretch_pkg::REG_STAT: begin
          axi_rdata_d = {20'h0, stretch_cycles(code_q), 1'b0, code_q,
                         3'h0, !req_ready};
        end
        default: begin
          axi_rdata_d = 32'h0;
          rresp_d = 2'h2;
        end
      endcase
    end
  end

  // external bus cycle sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q - 5'h01;
    code_d = code_q;
    short_d = short_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    case (state_q)
      ext_data_mem_stretch_pkg::S_IDLE: begin
        cnt_d = cnt_q;
        if (start) begin
          code_d = ctrl_q[`EDMS_SEL_MSB:`EDMS_SEL_LSB];
          short_d = page_q == 3'h3;
          wr_d = req_write;
          addr_d = req_ptr8 ? {port2_value, req_addr[7:0]} : req_addr;
          wdata_d = req_wdata;
          cnt_d = ale_len(code_d) - 5'h01;
          state_d = ext_data_mem_stretch_pkg::S_ALE;
        end
      end
      ext_data_mem_stretch_pkg::S_ALE: begin
        if (cnt_q == 5'h0) begin
          cnt_d = setup_len(code_q) - 5'h01;
          state_d = ext_data_mem_stretch_pkg::S_SETUP;
        end
      end
      ext_data_mem_stretch_pkg::S_SETUP: begin
        if (cnt_q == 5'h0) begin
          cnt_d = strobe_len(code_q, short_q) - 5'h01;
          state_d = ext_data_mem_stretch_pkg::S_STROBE;
        end
      end
      ext_data_mem_stretch_pkg::S_STROBE: begin
        if (cnt_q == 5'h0) begin
          cnt_d = hold_len(code_q, short_q) - 5'h01;
          state_d = ext_data_mem_stretch_pkg::S_HOLD;
        end
      end
      ext_data_mem_stretch_pkg::S_HOLD: begin
        // the synchroniser lags two clocks: take the byte of the last strobe clock
        if (!wr_q && cnt_q == hold_len(code_q, short_q) - 5'h02) begin
          rdata_d = ad_s2_q;
        end
        if (cnt_q == 5'h0) begin
          done_d = 1'b1;
          state_d = ext_data_mem_stretch_pkg::S_IDLE;
        end
      end
      default: state_d = ext_data_mem_stretch_pkg::S_IDLE;
    endcase
    ale_d = state_d == ext_data_mem_stretch_pkg::S_ALE;
    rd_n_d = !(state_d == ext_data_mem_stretch_pkg::S_STROBE && !wr_d);
    wr_n_d = !(state_d == ext_data_mem_stretch_pkg::S_STROBE && wr_d);
    ad_oe_d = ale_d || (wr_d && state_d != ext_data_mem_stretch_pkg::S_IDLE);
    ad_o_d = ale_d ? addr_d[7:0] : wdata_d;
  end

  // registers
  always_ff @(posedge aclk) begin
    ad_s1_q <= ad_i;
    ad_s2_q <= ad_s1_q;
    if (!aresetn) begin
      state_q <= ext_data_mem_stretch_pkg::S_IDLE;
      ctrl_q <= `EDMS_CTRL_RST;
      page_q <= `EDMS_PAGE_RST;
      cnt_q <= 5'h0;
      code_q <= 3'h0;
      short_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0;
      wdata_q <= 8'h0;
      rdata_q <= 8'h0;
      done_q <= 1'b0;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ad_oe_q <= 1'b0;
      ad_o_q <= 8'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      axi_rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      page_q <= page_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      short_q <= short_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      ale_q <= ale_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      ad_oe_q <= ad_oe_d;
      ad_o_q <= ad_o_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      axi_rdata_q <= axi_rdata_d;
    end
  end
  // outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = axi_rdata_q;
  assign done = done_q;
  assign rdata = rdata_q;
  assign ale = ale_q;
  assign rd_n = rd_n_q;
  assign wr_n = wr_n_q;
  assign ad_oe = ad_oe_q;
  assign ad_o = ad_o_q;
  assign addr_hi = addr_q[15:8];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // helper counters: strobe run and whole access length
  logic [5:0] strb_run_q, acc_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strb_run_q <= 6'h0;
      acc_run_q <= 6'h0;
    end else begin
      strb_run_q <= (!rd_n_q || !wr_n_q) ? strb_run_q + 6'h01 : 6'h0;
      acc_run_q <= ale_d && !ale_q ? 6'h01 : acc_run_q + 6'h01;
    end
  end

  sequence setup_one_s;
    (state_q == ext_data_mem_stretch_pkg::S_SETUP) [*3]
      ##1 (state_q == ext_data_mem_stretch_pkg::S_STROBE);
  endsequence

  sequence ale_slow_s;
    ale_q [*6] ##1 !ale_q;
  endsequence

  strobe_width_a: assert property ($rose(rd_n_q && wr_n_q) |->
    strb_run_q == {1'b0, strobe_len(code_q, short_q)})
    else $error("strobe width differs from code");
  access_length_a: assert property (done_d |->
    acc_run_q == {stretch_cycles(code_q) + 4'h2, 2'b00})
    else $error("access length wrong");
  zero_stretch_a: assert property ($rose(ale_q) && code_q == 3'h0 |->
    ##[1:7] done_d)
    else $error("zero stretch access too long");
  stretch_cycles_a: assert property (done_d && code_q inside {3'h1, 3'h2, 3'h3} |->
    acc_run_q == 6'h08 + {1'b0, code_q, 2'b00})
    else $error("stretch cycles not added");
  setup_first_a: assert property ($rose(state_q == ext_data_mem_stretch_pkg::S_SETUP)
    && code_q == 3'h1 |-> setup_one_s)
    else $error("first stretch setup wrong");
  ale_slow_a: assert property ($rose(ale_q) && code_q[2] |-> ale_slow_s)
    else $error("slow latch pulse wrong");
  sel_held_a: assert property (state_q != ext_data_mem_stretch_pkg::S_IDLE
    && $past(state_q) != ext_data_mem_stretch_pkg::S_IDLE |-> $stable(code_q))
    else $error("selection changed mid access");
  ctrl_write_a: assert property (wr_fire && wsel == ext_data_mem_stretch_pkg::REG_CTRL
    && s_axi_wstrb[0] |=> ctrl_q == $past(s_axi_wdata[7:0]))
    else $error("control write lost");
  reset_sel_a: assert property (disable iff (1'b0) !aresetn |=>
    ctrl_q[2:0] == 3'h1)
    else $error("stretch reset value wrong");
  ptr8_high_a: assert property (start && req_ptr8 |=>
    addr_hi == $past(port2_value) && $past(state_q) == ext_data_mem_stretch_pkg::S_IDLE)
    else $error("port 2 high byte not used");
  strobe_excl_a: assert property (!(rd_n_q == 1'b0 && wr_n_q == 1'b0))
    else $error("both strobes active");
endmodule // ext_data_mem_stretch

// ===== design/ext_data_mem_stretch_params.svh
`ifndef EXT_DATA_MEM_STRETCH_PARAMS_SVH
`define EXT_DATA_MEM_STRETCH_PARAMS_SVH
// ----------------------------------------
// register map, word index and byte address
// ----------------------------------------
`define EDMS_CTRL_IDX 12'h08E
`define EDMS_PAGE_ADDR 12'h000
`define EDMS_STAT_ADDR 12'h004
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EDMS_SEL_LSB 0
`define EDMS_SEL_MSB 2
`define EDMS_CTRL_RST 8'h01
`define EDMS_PAGE_RST 3'h0
// ----------------------------------------
// timing: clock period in ns, phase lengths in system clocks
// ----------------------------------------
`define EDMS_CLK_PERIOD_NS 100
`define EDMS_CLKS_PER_CYCLE 5'h04
`define EDMS_ALE_BASE 5'h02
`define EDMS_PHASE_BASE 5'h02
`define EDMS_PHASE_MID 5'h03
`define EDMS_PHASE_SLOW 5'h07
`define EDMS_ALE_SLOW 5'h06
`endif

// ===== design/ext_data_mem_stretch_pkg.sv
package ext_data_mem_stretch_pkg;
  // bus cycle phases
  typedef enum logic [2:0] {
    S_IDLE,
    S_ALE,
    S_SETUP,
    S_STROBE,
    S_HOLD
  } phase_t;
  // register selected by an address
  typedef enum logic [1:0] {
    REG_NONE,
    REG_CTRL,
    REG_PAGE,
    REG_STAT
  } reg_sel_t;
endpackage

// ===== tb/ext_sram_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// external byte memory on the multiplexed bus
// ----------------------------------------
module ext_sram_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad_o,
  input wire logic ad_oe,
  output logic [7:0] sram_q
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_q;
  logic [7:0] last_q = 8'h00;
  logic [3:0] rd_cnt_q = 4'h0;
  // latch low address in ale, store while write strobe low, age the read strobe
  always @(posedge aclk) begin
    if (ale && ad_oe) lo_q <= ad_o;
    if (!wr_n && ad_oe) mem[{addr_hi, lo_q}] <= ad_o;
    rd_cnt_q <= rd_n ? 4'h0 : ((rd_cnt_q == 4'hF) ? rd_cnt_q : rd_cnt_q + 4'h1);
    last_q <= sram_q;
  end
  // a slow part shows data after six strobe clocks; a released bus toggles
  always_comb begin
    if (!rd_n && (!slow || rd_cnt_q >= 4'h6)) sram_q = mem[{addr_hi, lo_q}];
    else sram_q = ~last_q;
  end
endmodule // ext_sram_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`include "ext_data_mem_stretch_params.svh"
module tb_top;
  localparam logic [11:0] CTRL_A = 12'(`EDMS_CTRL_IDX * 4);
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic req_valid = 0, req_write = 0, req_ptr8 = 0, req_ready, done, ale, rd_n, wr_n, ad_oe;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, port2_value = 8'h00, mem_rdata, addr_hi, ad_o, sram_q, bus;
  int err_total = 0, num_checks = 0, cyc, n_ale, n_set, n_stb, n_tot;
  logic [7:0] hi_seen;
  ext_data_mem_stretch i_ext_data_mem_stretch (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_ptr8(req_ptr8), .req_addr(req_addr), .req_wdata(req_wdata),
    .port2_value(port2_value), .done(done), .rdata(mem_rdata), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .addr_hi(addr_hi), .ad_i(bus), .ad_o(ad_o), .ad_oe(ad_oe));
  ext_sram_model i_ext_sram_model (.aclk(aclk), .slow(slow), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .addr_hi(addr_hi), .ad_o(ad_o), .ad_oe(ad_oe), .sram_q(sram_q));
  // wire level from both drivers
  assign bus = ad_oe ? ad_o : sram_q;
  // 100 ns clock
  always #50 aclk = ~aclk;
  // ----------------------------------------
  // bus phase monitor, counted from the taking edge
  // ----------------------------------------
  always @(posedge aclk) begin
    if (req_valid && req_ready === 1'b1) begin
      cyc = 0; n_ale = 0; n_set = 0; n_stb = 0;
    end else cyc = cyc + 1;
    if (ale === 1'b1) n_ale++;
    if (rd_n === 1'b0 || wr_n === 1'b0) begin
      n_stb++; hi_seen = addr_hi;
    end else if (ale === 1'b0 && n_ale > 0 && n_stb == 0) n_set++;
    if (done === 1'b1) n_tot = cyc - 1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 300) begin
      chk("wait", 0, 1);
      stop_test();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 300);
    bready <= 1'b0;
    bound(n);
    chk("bresp", er, bresp);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 300);
    rready <= 1'b0;
    bound(n);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask
  task automatic access(input logic w, input logic p8, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    req_valid <= 1'b1; req_write <= w; req_ptr8 <= p8; req_addr <= a; req_wdata <= d;
    do begin @(posedge aclk); n++; end while (req_ready !== 1'b1 && n < 300);
    req_valid <= 1'b0;
    do begin @(posedge aclk); n++; end while (done !== 1'b1 && n < 300);
    bound(n);
    @(negedge aclk);
  endtask
  task automatic timing(input int c, input int pg);
    chk("total", 4 * (2 + ((c < 4) ? c : c + 3)), n_tot);
    chk("ale", (c > 3) ? 6 : 2, n_ale);
    chk("setup", (c == 0) ? 2 : ((c < 4) ? 3 : 7), n_set);
    chk("strobe", ((c == 0) ? 2 : 4 * c) - pg, n_stb);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CTRL_A, `EDMS_CTRL_RST, 2'h0);
    chk("idle strobes", 2'h3, {rd_n, wr_n});
    axi_wr(12'hFFC, 32'h5, 2'h2);
    axi_rd(12'hFFC, 32'h0, 2'h2);
    $display("test reset and map done");
    for (int c = 0; c < 8; c++) begin
      axi_wr(CTRL_A, 32'hF8 | c, 2'h0);
      axi_rd(CTRL_A, 32'hF8 | c, 2'h0);
      access(1'b1, 1'b0, 16'h1200 + 16'(c), 8'hA0 + 8'(c));
      timing(c, 0);
      access(1'b0, 1'b0, 16'h1200 + 16'(c), 8'h00);
      timing(c, 0);
      chk("read byte", 8'hA0 + 8'(c), mem_rdata);
      axi_rd(`EDMS_STAT_ADDR, (((c < 4) ? c : c + 3) << 8) | (c << 4), 2'h0);
    end
    $display("test stretch codes done");
    axi_wr(CTRL_A, 32'h4, 2'h0);
    fork
      access(1'b0, 1'b0, 16'h1204, 8'h00);
      begin
        repeat (3) @(posedge aclk);
        axi_wr(CTRL_A, 32'h0, 2'h0);
      end
    join
    timing(4, 0);
    access(1'b0, 1'b0, 16'h1204, 8'h00);
    timing(0, 0);
    $display("test mid change done");
    @(posedge aclk);
    port2_value <= 8'h5A;
    access(1'b1, 1'b1, 16'h0033, 8'h77);
    chk("addr high", 8'h5A, hi_seen);
    access(1'b0, 1'b0, 16'h5A33, 8'h00);
    chk("ptr8 byte", 8'h77, mem_rdata);
    $display("test pointer done");
    axi_wr(`EDMS_PAGE_ADDR, 32'h3, 2'h0);
    for (int c = 0; c < 3; c += 2) begin
      axi_wr(CTRL_A, c, 2'h0);
      access(1'b0, 1'b0, 16'h1200, 8'h00);
      timing(c, 1);
      chk("page byte", 8'hA0, mem_rdata);
    end
    axi_wr(`EDMS_PAGE_ADDR, 32'h0, 2'h0);
    $display("test page done");
    slow <= 1'b1;
    axi_wr(CTRL_A, 32'h4, 2'h0);
    access(1'b0, 1'b0, 16'h1206, 8'h00);
    chk("slow byte", 8'hA6, mem_rdata);
    $display("test slow memory done");
    stop_test();
  end
endmodule // tb_top
